/* File: bench/scp_card.sv */
`timescale 1ns/1ps
module scp_card #(
  parameter int ETU = 744
) (
  // system
  input  wire logic clk,
  // card line, pulled up
  input  wire logic line,
  output logic      drive_low = 1'b0
);
  logic [9:0] got;
  logic       nack_seen;
  logic       listen = 1'b0;
  int         frames = 0;
  int         nacks = 0;
  int         cyc = 0;
  int         last = 0;
  int         gap = 0;
  always @(posedge clk) cyc <= cyc + 1;
  // receiver: samples mid bit, optionally answers with an error signal
  always begin
    @(negedge line iff listen);
    gap = cyc - last;
    last = cyc;
    repeat (ETU / 2) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      got[i] = line;
      if (i < 9) repeat (ETU) @(posedge clk);
    end
    frames++;
    if (nacks > 0) begin
      nacks--;
      repeat (ETU * 3 / 4) @(posedge clk);
      drive_low <= 1'b1;
      repeat (ETU * 5 / 4) @(posedge clk);
      drive_low <= 1'b0;
    end
  end
  // sender: levels lsb first, start bit included, then error window
  task automatic send(input logic [9:0] lv);
    begin
      for (int i = 0; i < 10; i++) begin
        drive_low <= ~lv[i];
        repeat (ETU) @(posedge clk);
      end
      drive_low <= 1'b0;
      repeat (ETU) @(posedge clk);
      nack_seen = ~line;
      repeat (ETU) @(posedge clk);
    end
  endtask : send
endmodule : scp_card

/* File: bench/scp_top_props.sv */
`timescale 1ns/1ps
module scp_top_props (
  // system
  input wire logic        clk,
  input wire logic        srst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // card line
  input wire logic        data_in,
  input wire logic        data_out,
  input wire logic        data_oe,
  input wire logic        card_clock_pin,
  // interrupts
  input wire logic        tx_irq,
  input wire logic        rx_irq,
  input wire logic        error_irq
);
  localparam int ETU_MIN = 744;
  logic [31:0] oe_len_reg;
  logic [31:0] oe_len_next;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence
  // length of the current low drive on the line
  always_comb begin
    oe_len_next = data_oe ? oe_len_reg + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk) begin
    oe_len_reg <= srst ? 32'h0 : oe_len_next;
  end
  a_apb_answer: assert property (setup_s |=> access_s)
    else $error("no pready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_no_slverr: assert property (pready |-> !pslverr)
    else $error("pslverr raised");
  a_read_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_unmapped_zero: assert property (psel && !penable && !pwrite && paddr == 32'h1C
    |=> prdata == 32'h0) else $error("unmapped read not zero");
  a_prdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data changed without read");
  a_open_drain: assert property (data_oe |-> !data_out)
    else $error("line driven high");
  a_bit_min_len: assert property ($fell(data_oe) && !$past(srst) |-> oe_len_reg >= ETU_MIN)
    else $error("low drive shorter than one bit");
  a_reset_quiet: assert property ($fell(srst) |-> !data_oe && !tx_irq && !rx_irq)
    else $error("outputs active after reset");
endmodule : scp_top_props

bind scp_top scp_top_props u_props (
  .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
  .card_clock_pin(card_clock_pin), .tx_irq(tx_irq), .rx_irq(rx_irq),
  .error_irq(error_irq));

/* File: bench/tb_smart_card_serial_port.sv */
`timescale 1ns/1ps
module tb_smart_card_serial_port;
  import scp_pkg::*;
  localparam int ETU = 744;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        data_out;
  logic        data_oe;
  logic        card_clk;
  logic        tx_irq;
  logic        rx_irq;
  logic        error_irq;
  logic        card_low;
  wire         line = !((data_oe && !data_out) || card_low);
  int          fail_count = 0;
  int          num_checks = 0;
  int          cyc = 0;
  always #10 clk = ~clk;
  scp_top dut (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
    .data_in(line), .data_out(data_out), .data_oe(data_oe), .card_clock_pin(card_clk),
    .tx_irq(tx_irq), .rx_irq(rx_irq), .error_irq(error_irq));
  scp_card #(.ETU(ETU)) u_card (.clk(clk), .line(line), .drive_low(card_low));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input string s, input logic [31:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(s, e, r & m);
  endtask : rd
  // expected line levels: start, eight data bits in wire order, parity
  function automatic logic [9:0] frame(input logic [7:0] d, input logic inv);
    logic [9:0] f;
    f[0] = 1'b0;
    for (int i = 0; i < 8; i++) f[i+1] = inv ? ~d[7-i] : d[i];
    f[9] = inv ? ~^d : ^d;
    return f;
  endfunction : frame
  task automatic init(input logic [7:0] mode, input logic [7:0] card, input logic [7:0] ctl);
    wr(SCP_CTRL_OFS, 32'h0);
    wr(SCP_STAT_OFS, 32'hC7);
    wr(SCP_MODE_OFS, {24'h0, mode});
    wr(SCP_CARD_OFS, {24'h0, card});
    wr(SCP_RATE_OFS, 32'h0);
    wr(SCP_CTRL_OFS, 32'h1);
    repeat (ETU) @(posedge clk);
    wr(SCP_CTRL_OFS, {24'h0, ctl});
  endtask : init
  task automatic wait_frames(input int k);
    for (int n = 0; u_card.frames < k && n < 30 * ETU; n++) @(posedge clk);
  endtask : wait_frames
  task automatic t_regs;
    rd("stat reset", SCP_STAT_OFS, ALL, 32'h84);
    rd("rate reset", SCP_RATE_OFS, ALL, 32'hFF);
    rd("card reset", SCP_CARD_OFS, ALL, 32'h0);
    rd("unmapped", 32'h1C, ALL, 32'h0);
    chk("idle pins", 32'h0, {28'h0, data_oe, card_clk, tx_irq, error_irq});
  endtask : t_regs
  task automatic t_clk;
    int p;
    for (int k = 0; k < 4; k++) begin
      wr(SCP_MODE_OFS, k);
      wr(SCP_RATE_OFS, k);
      wr(SCP_CARD_OFS, 32'h1);
      wr(SCP_CTRL_OFS, 32'h1);
      p = 0;
      while (card_clk !== 1'b0 && p < 999) @(posedge clk) p++;
      while (card_clk !== 1'b1 && p < 999) @(posedge clk) p++;
      p = 0;
      do @(posedge clk) p++; while (card_clk !== 1'b0 && p < 999);
      do @(posedge clk) p++; while (card_clk !== 1'b1 && p < 999);
      chk("card clock period", 2 * (4 ** k) * (k + 1), p);
    end
  endtask : t_clk
  task automatic t_tx_retry;
    init(8'h10, 8'h0D, 8'hE1);
    rd("stat before load", SCP_STAT_OFS, ALL, 32'h84);
    u_card.nacks = 1;
    u_card.listen = 1'b1;
    wr(SCP_TXD_OFS, 32'h3F);
    wr(SCP_STAT_OFS, 32'h7F);
    rd("done after start", SCP_STAT_OFS, 32'h04, 32'h0);
    wait_frames(1);
    chk("first frame", frame(8'h3F, 1'b1), u_card.got);
    wait_frames(2);
    chk("resent frame", frame(8'h3F, 1'b1), u_card.got);
    chk("resend gap", 32'h1, u_card.gap >= 12 * ETU);
    for (int n = 0; tx_irq !== 1'b1 && n < 6 * ETU; n++) @(posedge clk);
    chk("tx irq", 32'h3, {tx_irq, error_irq});
    rd("error and done", SCP_STAT_OFS, 32'h14, 32'h14);
    u_card.listen = 1'b0;
  endtask : t_tx_retry
  task automatic t_rx;
    init(8'h00, 8'h01, 8'h51);
    u_card.send(frame(8'h3B, 1'b0));
    chk("good frame error signal", 32'h0, u_card.nack_seen);
    chk("rx irq", 32'h1, rx_irq);
    rd("rx flags", SCP_STAT_OFS, 32'h78, 32'h40);
    rd("rx data", SCP_RXD_OFS, ALL, 32'h3B);
    wr(SCP_STAT_OFS, 32'hBF);
    u_card.send(frame(8'h5A, 1'b0) ^ 10'h200);
    chk("parity error signal", 32'h1, u_card.nack_seen);
    rd("parity flags", SCP_STAT_OFS, 32'h48, 32'h08);
    rd("bad parity data", SCP_RXD_OFS, ALL, 32'h5A);
    chk("error irq", 32'h1, {rx_irq, error_irq});
  endtask : t_rx
  task automatic final_report;
    if (fail_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      fail_count++;
      $display("BAD timeout exp done got hang");
      final_report();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_clk();
    t_tx_retry();
    t_rx();
    final_report();
  end
endmodule : tb_smart_card_serial_port

/* File: hdl/scp_baud.sv */
`timescale 1ns/1ps
// basic clock of 372 ticks per bit plus card clock
module scp_baud (
  // system
  input  wire logic              clk,
  input  wire logic              srst,
  // settings
  input  wire scp_pkg::scp_cfg_t cfg,
  // outputs
  output logic                   tick,
  output logic                   card_clk
);
  import scp_pkg::*;

  logic [16:0] pre_reg;
  logic [16:0] pre_next;
  logic [16:0] pre_last;
  logic        ck_reg;
  logic        ck_next;

  // half-period of basic clock = 2^(2n) * (N+1) system clocks
  always_comb begin
    pre_last = 17'((({9'd0, cfg.divisor} + 17'd1) << (2 * cfg.cks)) * SCP_PRE_BASE - 1);
  end

  always_comb begin
    pre_next = pre_reg + 17'd1;
    ck_next  = ck_reg;
    if (!cfg.card_mode_select) begin
      pre_next = '0;
      ck_next  = 1'b0;
    end else if (pre_reg >= pre_last) begin
      pre_next = '0;
      ck_next  = ~ck_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pre_reg  <= '0;
      ck_reg   <= 1'b0;
      tick     <= 1'b0;
      card_clk <= 1'b0;
    end else begin
      pre_reg  <= pre_next;
      ck_reg   <= ck_next;
      tick     <= cfg.card_mode_select && pre_reg >= pre_last && ck_reg;
      card_clk <= cfg.cke && ck_next;
    end
  end
endmodule : scp_baud

/* File: hdl/scp_pkg.sv */
package scp_pkg;
  localparam logic [31:0] SCP_MODE_OFS   = 32'h0000_0000;
  localparam logic [31:0] SCP_RATE_OFS   = 32'h0000_0004;
  localparam logic [31:0] SCP_CTRL_OFS   = 32'h0000_0008;
  localparam logic [31:0] SCP_TXD_OFS    = 32'h0000_000C;
  localparam logic [31:0] SCP_STAT_OFS   = 32'h0000_0010;
  localparam logic [31:0] SCP_RXD_OFS    = 32'h0000_0014;
  localparam logic [31:0] SCP_CARD_OFS   = 32'h0000_0018;
  // mode register fields
  localparam int SCP_MODE_ODD_BIT = 4;
  localparam int SCP_MODE_CKS_LO  = 0;
  localparam logic [7:0] SCP_MODE_RST = 8'h00;
  // control register fields
  localparam int SCP_CTRL_TIE_BIT = 7;
  localparam int SCP_CTRL_RIE_BIT = 6;
  localparam int SCP_CTRL_TE_BIT  = 5;
  localparam int SCP_CTRL_RE_BIT  = 4;
  localparam int SCP_CTRL_CKE_BIT = 0;
  localparam logic [7:0] SCP_CTRL_RST = 8'h00;
  // status register fields
  localparam int SCP_ST_TX_BUFFER_EMPTY_FLAG_BIT = 7;
  localparam int SCP_ST_RX_FULL_FLAG_BIT = 6;
  localparam int SCP_ST_OVERRUN_FLAG_BIT = 5;
  localparam int SCP_ST_ERS_BIT  = 4;
  localparam int SCP_ST_PER_BIT  = 3;
  localparam int SCP_ST_TX_DONE_FLAG_BIT = 2;
  // card mode register fields; rate register reset value
  localparam int SCP_CARD_DIR_BIT = 3;
  localparam int SCP_CARD_INV_BIT = 2;
  localparam int SCP_CARD_CARD_MODE_SELECT_BIT = 0;
  localparam logic [7:0] SCP_RATE_RST = 8'hFF;
  // timing in basic-clock ticks and bit periods
  localparam int          SCP_TICKS_PER_BIT = 372;
  localparam logic [8:0]  SCP_ETU_LAST      = 9'd371;
  localparam logic [8:0]  SCP_HALF_ETU      = 9'd186;
  localparam int          SCP_PRE_BASE      = 1488 / 372 / 4;
  localparam logic [3:0]  SCP_RX_ERR_BIT    = 4'd10;
  localparam logic [3:0]  SCP_TX_ERS_BIT    = 4'd11;
  localparam logic [3:0]  SCP_TX_END_BIT    = 4'd12;
  localparam logic [3:0]  SCP_TX_RETRY_BIT  = 4'd13;

  typedef struct packed {
    logic       odd;
    logic [1:0] cks;
    logic [7:0] divisor;
    logic       cke;
    logic       dir_msb;
    logic       inv;
    logic       card_mode_select;
  } scp_cfg_t;
endpackage : scp_pkg

/* File: hdl/scp_top.sv */
`timescale 1ns/1ps
module scp_top (
  // system
  input  wire logic        clk,
  input  wire logic        srst,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // card line, open drain
  input  wire logic        data_in,
  output logic             data_out,
  output logic             data_oe,
  output logic             card_clock_pin,
  // interrupts
  output logic             tx_irq,
  output logic             rx_irq,
  output logic             error_irq
);
  import scp_pkg::*;

  typedef enum logic [4:0] {
    SCP_IDLE  = 5'b00001,
    SCP_TX    = 5'b00010,
    SCP_RX    = 5'b00100,
    SCP_RXERR = 5'b01000,
    SCP_GUARD = 5'b10000
  } scp_state_t;

  function automatic logic sel_bit(input logic [7:0] d, input logic msb, input logic [3:0] i);
    sel_bit = msb ? d[3'(7 - i)] : d[3'(i)];
  endfunction : sel_bit

  // registers
  logic [7:0]  mode_reg;
  logic [7:0]  mode_next;
  logic [7:0]  rate_reg;
  logic [7:0]  rate_next;
  logic [7:0]  ctrl_reg;
  logic [7:0]  ctrl_next;
  logic [7:0]  card_reg;
  logic [7:0]  card_next;
  logic [7:0]  txd_reg;
  logic [7:0]  txd_next;
  logic [7:0]  rxd_reg;
  logic [7:0]  rxd_next;
  logic        tx_buffer_empty_flag_reg;
  logic        tx_buffer_empty_flag_next;
  logic        rx_full_flag_reg;
  logic        rx_full_flag_next;
  logic        overrun_flag_reg;
  logic        overrun_flag_next;
  logic        ers_reg;
  logic        ers_next;
  logic        per_reg;
  logic        per_next;
  logic        tx_done_flag_reg;
  logic        tx_done_flag_next;
  logic        tx_buffer_empty_flag_rd_reg;
  logic        tx_buffer_empty_flag_rd_next;
  scp_cfg_t    cfg;
  logic        tick;
  logic        card_clk;
  logic        rx_s1;
  logic        rx_s2;
  logic        rx_prev;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;

  // transfer engine
  scp_state_t  st_reg;
  scp_state_t  st_next;
  logic [8:0]  tk_reg;
  logic [8:0]  tk_next;
  logic [3:0]  bit_reg;
  logic [3:0]  bit_next;
  logic [7:0]  sh_reg;
  logic [7:0]  sh_next;
  logic        par_reg;
  logic        par_next;
  logic        drv_reg;
  logic        drv_next;
  logic        err_seen_reg;
  logic        err_seen_next;
  logic        set_tx_done_flag;
  logic        set_ers;
  logic        set_rx_full_flag;
  logic        set_per;
  logic        set_overrun_flag;
  logic        clr_tx_done_flag;
  logic [7:0]  rx_word;

  assign cfg = '{odd: mode_reg[SCP_MODE_ODD_BIT], cks: mode_reg[SCP_MODE_CKS_LO +: 2],
                 divisor: rate_reg, cke: ctrl_reg[SCP_CTRL_CKE_BIT],
                 dir_msb: card_reg[SCP_CARD_DIR_BIT], inv: card_reg[SCP_CARD_INV_BIT],
                 card_mode_select: card_reg[SCP_CARD_CARD_MODE_SELECT_BIT]};

  scp_baud u_baud (
    .clk      (clk),
    .srst     (srst),
    .cfg      (cfg),
    .tick     (tick),
    .card_clk (card_clk)
  );

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;

  // rebuild data from received shift bits, undo order and inversion
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      rx_word[i] = sel_bit(sh_reg, cfg.dir_msb, 4'(i)) ^ cfg.inv;
    end
  end

  // transfer state machine
  always_comb begin
    st_next       = st_reg;
    tk_next       = tk_reg;
    bit_next      = bit_reg;
    sh_next       = sh_reg;
    par_next      = par_reg;
    drv_next      = 1'b0;
    err_seen_next = err_seen_reg;
    set_tx_done_flag = 1'b0;
    set_ers  = 1'b0;
    set_rx_full_flag = 1'b0;
    set_per  = 1'b0;
    set_overrun_flag = 1'b0;
    clr_tx_done_flag = 1'b0;
    case (st_reg)
      SCP_IDLE: begin
        tk_next  = '0;
        bit_next = '0;
        // start on a tick so the start bit spans a whole etu
        if (cfg.card_mode_select && ctrl_reg[SCP_CTRL_TE_BIT] && !tx_buffer_empty_flag_reg && tick) begin
          st_next       = SCP_TX;
          sh_next       = txd_reg;
          err_seen_next = 1'b0;
        end else if (cfg.card_mode_select && ctrl_reg[SCP_CTRL_RE_BIT] && rx_prev && !rx_s2) begin
          st_next  = SCP_RX;
          par_next = 1'b0;
        end
      end
      SCP_TX: begin
        // start, 8 data, parity driven; line released after
        if (bit_reg == 4'd0) drv_next = 1'b1;
        else if (bit_reg <= 4'd8)
          drv_next = ~(sel_bit(sh_reg, cfg.dir_msb, bit_reg - 4'd1) ^ cfg.inv);
        else if (bit_reg == 4'd9)
          drv_next = ~((^sh_reg) ^ cfg.odd); // parity on raw data, no inversion
        if (tick) begin
          tk_next = tk_reg + 9'd1;
          // error signal sampled mid-bit 11
          if (bit_reg == SCP_TX_ERS_BIT - 4'd1 && tk_reg == SCP_HALF_ETU && !rx_s2)
            err_seen_next = 1'b1;
          if (tk_reg == SCP_ETU_LAST) begin
            tk_next  = '0;
            bit_next = bit_reg + 4'd1;
            if (bit_reg == SCP_TX_ERS_BIT - 4'd1) set_ers = err_seen_reg;
            if (bit_reg == SCP_TX_RETRY_BIT - 4'd1 && err_seen_reg) begin
              st_next  = SCP_TX; // resend same character
              bit_next = '0;
              err_seen_next = 1'b0;
            end else if (bit_reg == SCP_TX_END_BIT - 4'd1 && !err_seen_reg) begin
              st_next  = SCP_IDLE; // two bits guard after parity
              set_tx_done_flag = 1'b1;
            end
          end
        end
        if (!ctrl_reg[SCP_CTRL_TE_BIT]) st_next = SCP_IDLE;
      end
      SCP_RX: begin
        if (tick) begin
          tk_next = tk_reg + 9'd1;
          if (tk_reg == SCP_HALF_ETU && bit_reg != 4'd0) begin
            if (bit_reg <= 4'd8) sh_next = {rx_s2, sh_reg[7:1]};
            else par_next = rx_s2;
          end
          if (tk_reg == SCP_ETU_LAST) begin
            tk_next  = '0;
            bit_next = bit_reg + 4'd1;
          end
          if (bit_reg == 4'd10 && tk_reg == '0) begin
            // check at 10 bit periods, error window opens at 10.5
            if ((^(rx_word ^ {8{cfg.inv}})) ^ par_reg ^ cfg.odd) begin
              set_per = 1'b1;
              if (rx_full_flag_reg) set_overrun_flag = 1'b1;
              st_next = SCP_RXERR;
              tk_next = '0;
            end else begin
              if (rx_full_flag_reg) set_overrun_flag = 1'b1;
              else set_rx_full_flag = 1'b1;
              st_next = SCP_GUARD;
            end
          end
        end
        if (!ctrl_reg[SCP_CTRL_RE_BIT]) st_next = SCP_IDLE;
      end
      SCP_RXERR: begin
        // low from 10.5 to 11.5 bit periods
        drv_next = tk_reg >= SCP_HALF_ETU || bit_reg == 4'd11;
        if (tick) begin
          tk_next = tk_reg + 9'd1;
          if (tk_reg == SCP_ETU_LAST) begin
            tk_next  = '0;
            bit_next = bit_reg + 4'd1;
          end
          if (bit_reg == 4'd11 && tk_reg == SCP_HALF_ETU) begin
            drv_next = 1'b0;
            st_next  = SCP_GUARD;
          end
        end
      end
      SCP_GUARD: begin
        if (rx_s2) st_next = SCP_IDLE;
      end
      default: st_next = SCP_IDLE;
    endcase
    if (!cfg.card_mode_select) st_next = SCP_IDLE;
    if (wr && paddr == SCP_STAT_OFS && tx_buffer_empty_flag_rd_reg && !pwdata[SCP_ST_TX_BUFFER_EMPTY_FLAG_BIT])
      clr_tx_done_flag = 1'b1;
  end

  // registers and flags; hardware set wins over software clear
  always_comb begin
    mode_next = mode_reg;
    rate_next = rate_reg;
    ctrl_next = ctrl_reg;
    card_next = card_reg;
    txd_next  = txd_reg;
    tx_buffer_empty_flag_rd_next = tx_buffer_empty_flag_rd_reg;
    tx_buffer_empty_flag_next = tx_buffer_empty_flag_reg;
    rx_full_flag_next = rx_full_flag_reg;
    overrun_flag_next = overrun_flag_reg;
    ers_next  = ers_reg;
    per_next  = per_reg;
    tx_done_flag_next = tx_done_flag_reg;
    rxd_next  = rxd_reg;
    if (rd && paddr == SCP_STAT_OFS) tx_buffer_empty_flag_rd_next = tx_buffer_empty_flag_reg;
    if (wr) begin
      case (paddr)
        SCP_MODE_OFS: mode_next = pwdata[7:0];
        SCP_RATE_OFS: rate_next = pwdata[7:0];
        SCP_CTRL_OFS: ctrl_next = pwdata[7:0];
        SCP_CARD_OFS: card_next = pwdata[7:0] & 8'h0D;
        SCP_TXD_OFS:  txd_next  = pwdata[7:0];
        SCP_STAT_OFS: begin
          if (tx_buffer_empty_flag_rd_reg && !pwdata[SCP_ST_TX_BUFFER_EMPTY_FLAG_BIT]) tx_buffer_empty_flag_next = 1'b0;
          if (!pwdata[SCP_ST_RX_FULL_FLAG_BIT]) rx_full_flag_next = 1'b0;
          if (!pwdata[SCP_ST_OVERRUN_FLAG_BIT]) overrun_flag_next = 1'b0;
          if (!pwdata[SCP_ST_ERS_BIT])  ers_next  = 1'b0;
          if (!pwdata[SCP_ST_PER_BIT])  per_next  = 1'b0;
          tx_buffer_empty_flag_rd_next = 1'b0;
        end
        default: ;
      endcase
    end
    if (clr_tx_done_flag) tx_done_flag_next = 1'b0;
    if (st_reg == SCP_IDLE && st_next == SCP_TX) tx_buffer_empty_flag_next = 1'b1;
    if (!ctrl_reg[SCP_CTRL_TE_BIT] && !ers_reg) tx_done_flag_next = 1'b1;
    if (set_tx_done_flag) tx_done_flag_next = 1'b1;
    if (set_ers)  ers_next  = 1'b1;
    if (set_per)  per_next  = 1'b1;
    if (set_overrun_flag) overrun_flag_next = 1'b1;
    if (set_rx_full_flag) rx_full_flag_next = 1'b1;
    if ((set_rx_full_flag || set_per) && !rx_full_flag_reg) rxd_next = rx_word;
  end

  always_comb begin
    rdata = '0;
    case (paddr)
      SCP_MODE_OFS: rdata[7:0] = mode_reg;
      SCP_RATE_OFS: rdata[7:0] = rate_reg;
      SCP_CTRL_OFS: rdata[7:0] = ctrl_reg;
      SCP_TXD_OFS:  rdata[7:0] = txd_reg;
      SCP_STAT_OFS: rdata[7:0] = {tx_buffer_empty_flag_reg, rx_full_flag_reg, overrun_flag_reg, ers_reg,
                                  per_reg, tx_done_flag_reg, 2'b00};
      SCP_RXD_OFS:  rdata[7:0] = rxd_reg;
      SCP_CARD_OFS: rdata[7:0] = card_reg;
      default:      rdata = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_reg <= SCP_MODE_RST;
      rate_reg <= SCP_RATE_RST;
      ctrl_reg <= SCP_CTRL_RST;
      card_reg <= '0;
      txd_reg  <= '0;
      rxd_reg  <= '0;
      tx_buffer_empty_flag_reg <= 1'b1;
      tx_buffer_empty_flag_rd_reg <= 1'b0;
      rx_full_flag_reg <= 1'b0;
      overrun_flag_reg <= 1'b0;
      ers_reg  <= 1'b0;
      per_reg  <= 1'b0;
      tx_done_flag_reg <= 1'b1;
      st_reg   <= SCP_IDLE;
      tk_reg   <= '0;
      bit_reg  <= '0;
      sh_reg   <= '0;
      par_reg  <= 1'b0;
      drv_reg  <= 1'b0;
      err_seen_reg <= 1'b0;
      rx_s1    <= 1'b1;
      rx_s2    <= 1'b1;
      rx_prev  <= 1'b1;
      prdata   <= '0;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      data_out <= 1'b0;
      data_oe  <= 1'b0;
      card_clock_pin <= 1'b0;
      tx_irq   <= 1'b0;
      rx_irq   <= 1'b0;
      error_irq <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      rate_reg <= rate_next;
      ctrl_reg <= ctrl_next;
      card_reg <= card_next;
      txd_reg  <= txd_next;
      rxd_reg  <= rxd_next;
      tx_buffer_empty_flag_reg <= tx_buffer_empty_flag_next;
      tx_buffer_empty_flag_rd_reg <= tx_buffer_empty_flag_rd_next;
      rx_full_flag_reg <= rx_full_flag_next;
      overrun_flag_reg <= overrun_flag_next;
      ers_reg  <= ers_next;
      per_reg  <= per_next;
      tx_done_flag_reg <= tx_done_flag_next;
      st_reg   <= st_next;
      tk_reg   <= tk_next;
      bit_reg  <= bit_next;
      sh_reg   <= sh_next;
      par_reg  <= par_next;
      drv_reg  <= drv_next;
      err_seen_reg <= err_seen_next;
      rx_s1    <= data_in;
      rx_s2    <= rx_s1;
      rx_prev  <= rx_s2;
      pready   <= psel && !penable;
      pslverr  <= 1'b0;
      if (rd) prdata <= rdata;
      data_out <= 1'b0;
      data_oe  <= cfg.card_mode_select && drv_next; // released pin is high Z
      card_clock_pin <= card_clk;
      tx_irq   <= tx_done_flag_next && ctrl_next[SCP_CTRL_TIE_BIT];
      rx_irq   <= rx_full_flag_next && ctrl_next[SCP_CTRL_RIE_BIT];
      error_irq <= (overrun_flag_next || per_next || ers_next) && ctrl_next[SCP_CTRL_RIE_BIT];
    end
  end
endmodule : scp_top
